// >>> include/sfcd_consts.vh
`ifndef SFCD_CONSTS_VH
`define SFCD_CONSTS_VH

// ************************************************************
// Opcodes
// ************************************************************
`define SFCD_OP_QUAD_OUTPUT_READ    8'h6b
`define SFCD_OP_QUAD_IO_READ        8'heb
`define SFCD_OP_WORD_QUAD_IO_READ   8'he7
`define SFCD_OP_OCTAL_WORD_READ     8'he3
`define SFCD_OP_PAGE_ERASE          8'h81
`define SFCD_OP_SECTOR_ERASE        8'h20
`define SFCD_OP_HALF_BLOCK_ERASE    8'h52
`define SFCD_OP_FULL_BLOCK_ERASE    8'hd8
`define SFCD_OP_ARRAY_ERASE_A       8'h60
`define SFCD_OP_ARRAY_ERASE_B       8'hc7
`define SFCD_OP_SINGLE_PROGRAM      8'h02
`define SFCD_OP_DUAL_PROGRAM        8'ha2
`define SFCD_OP_QUAD_PROGRAM        8'h32
`define SFCD_OP_SUSPEND_A           8'h75
`define SFCD_OP_SUSPEND_B           8'hb0
`define SFCD_OP_RESUME_A            8'h7a
`define SFCD_OP_RESUME_B            8'h30
`define SFCD_OP_SET_WRITE_LATCH     8'h06
`define SFCD_OP_BLOCK_LOCK          8'h36
`define SFCD_OP_SECURE_ERASE        8'h44
`define SFCD_OP_SECURE_PROGRAM      8'h42

// ************************************************************
// Frame layout
// ************************************************************
`define SFCD_OPCODE_BITS            4'h8
`define SFCD_ADDR_BITS              5'h18
`define SFCD_DUMMY_BITS             4'h8
`define SFCD_BYTE_BITS              4'h8

// ************************************************************
// Data phase direction
// ************************************************************
`define SFCD_DIR_NONE               2'h0
`define SFCD_DIR_IN                 2'h1
`define SFCD_DIR_OUT                2'h2

// ************************************************************
// Low address bits forced to zero per read granule
// ************************************************************
`define SFCD_GRAN_BYTE              4'h0
`define SFCD_GRAN_WORD              4'h1
`define SFCD_GRAN_OCTAL_WORD        4'hf

// ************************************************************
// Reset values
// ************************************************************
`define SFCD_RESET_OPCODE           8'h00
`define SFCD_RESET_ADDR             24'h000000

`endif

// >>> rtl/sfcd_pin_sync.v
`timescale 1ns/1ps
// ************************************************************
// Three-stage pin synchroniser with agreement filter
// ************************************************************
module sfcd_pin_sync #(
    parameter WIDTH = 6,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    input  wire             clk,
    input  wire             reset,
    input  wire [WIDTH-1:0] pin,
    output reg  [WIDTH-1:0] level
);
    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;
    reg [WIDTH-1:0] stage3;
    genvar i;

    always @(posedge clk) begin
        if (reset) begin
            stage1 <= INIT;
            stage2 <= INIT;
            stage3 <= INIT;
        end else begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // A bit only moves once two late stages agree
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always @(posedge clk) begin
                if (reset) begin
                    level[i] <= INIT[i];
                end else if (stage2[i] == stage3[i]) begin
                    level[i] <= stage3[i];
                end
            end
        end
    endgenerate
endmodule // sfcd_pin_sync

// >>> rtl/sfcd_cmd_table.v
`timescale 1ns/1ps
`include "sfcd_consts.vh"
// ************************************************************
// Opcode lookup: frame shape of each command
// ************************************************************
module sfcd_cmd_table (
    input  wire [7:0] opcode,
    output reg        known,
    output reg        has_addr,
    output reg  [2:0] addr_lines,
    output reg        has_dummy,
    output reg  [2:0] dummy_lines,
    output reg  [1:0] dir,
    output reg  [2:0] data_lines,
    output reg  [3:0] gran_mask,
    output reg        needs_latch
);
    always @* begin
        known       = 1'b1;
        has_addr    = 1'b1;
        addr_lines  = 3'h1;
        has_dummy   = 1'b0;
        dummy_lines = 3'h1;
        dir         = `SFCD_DIR_NONE;
        data_lines  = 3'h1;
        gran_mask   = `SFCD_GRAN_BYTE;
        needs_latch = 1'b0;
        case (opcode)
            `SFCD_OP_QUAD_OUTPUT_READ: begin
                has_dummy  = 1'b1;
                dir        = `SFCD_DIR_OUT;
                data_lines = 3'h4;
            end
            `SFCD_OP_QUAD_IO_READ, `SFCD_OP_WORD_QUAD_IO_READ, `SFCD_OP_OCTAL_WORD_READ: begin
                addr_lines  = 3'h4;
                has_dummy   = 1'b1;
                dummy_lines = 3'h4;
                dir         = `SFCD_DIR_OUT;
                data_lines  = 3'h4;
                if (opcode == `SFCD_OP_WORD_QUAD_IO_READ) begin
                    gran_mask = `SFCD_GRAN_WORD;
                end else if (opcode == `SFCD_OP_OCTAL_WORD_READ) begin
                    gran_mask = `SFCD_GRAN_OCTAL_WORD;
                end
            end
            `SFCD_OP_PAGE_ERASE, `SFCD_OP_SECTOR_ERASE, `SFCD_OP_HALF_BLOCK_ERASE,
            `SFCD_OP_FULL_BLOCK_ERASE, `SFCD_OP_SECURE_ERASE: begin
                needs_latch = 1'b1;
            end
            `SFCD_OP_BLOCK_LOCK: begin
                needs_latch = 1'b0;
            end
            `SFCD_OP_ARRAY_ERASE_A, `SFCD_OP_ARRAY_ERASE_B: begin
                has_addr    = 1'b0;
                needs_latch = 1'b1;
            end
            `SFCD_OP_SINGLE_PROGRAM, `SFCD_OP_SECURE_PROGRAM, `SFCD_OP_DUAL_PROGRAM,
            `SFCD_OP_QUAD_PROGRAM: begin
                dir         = `SFCD_DIR_IN;
                needs_latch = 1'b1;
                if (opcode == `SFCD_OP_DUAL_PROGRAM) begin
                    data_lines = 3'h2;
                end else if (opcode == `SFCD_OP_QUAD_PROGRAM) begin
                    data_lines = 3'h4;
                end
            end
            `SFCD_OP_SUSPEND_A, `SFCD_OP_SUSPEND_B, `SFCD_OP_RESUME_A, `SFCD_OP_RESUME_B,
            `SFCD_OP_SET_WRITE_LATCH: begin
                has_addr = 1'b0;
            end
            default: begin
                known    = 1'b0;
                has_addr = 1'b0;
            end
        endcase
    end
endmodule // sfcd_cmd_table

// >>> rtl/sfcd_decoder.v
`timescale 1ns/1ps
`include "sfcd_consts.vh"
// What this block does
// - 6Bh: address, dummy byte, quad output read
// - EBh: quad address and dummy, quad read
// - E7h: quad read, word granular
// - E3h: quad read, octal word granular
// - 81h: address only, erases page
// - 20h: address only, erases 4K sector
// - 52h: address only, erases 32K block
// - D8h: address only, erases 64K block
// - 60h or C7h: whole array erase
// - 02h: address, data bytes on one line
// - A2h: address, data bytes on two lines
// - 32h: address, data bytes on four lines
// - 75h or B0h suspends program or erase
// - 7Ah or 30h resumes suspended operation
// - 06h sets write enable latch
// - 36h plus address locks one block
// - 44h plus address erases security register
// - 42h plus address, data programs security registers
module sfcd_decoder (
    input  wire        clk,
    input  wire        reset,
    input  wire        cs_n_pin,
    input  wire        sclk_pin,
    input  wire [3:0]  io_in,
    output reg  [3:0]  io_out,
    output reg  [3:0]  io_oe,
    output reg         cmd_valid,
    output reg  [7:0]  cmd_opcode,
    output reg  [23:0] cmd_addr,
    output reg         suspend_req,
    output reg         resume_req,
    output reg         prog_byte_valid,
    output reg  [7:0]  prog_byte,
    output reg  [23:0] prog_addr,
    output reg         rd_req,
    output reg  [23:0] rd_addr,
    input  wire [7:0]  rd_byte,
    input  wire        op_done,
    output reg         write_latch
);
    // ************************************************************
    // States
    // ************************************************************
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_OPC   = 3'h1;
    localparam [2:0] ST_ADDR  = 3'h2;
    localparam [2:0] ST_DUMMY = 3'h3;
    localparam [2:0] ST_DIN   = 3'h4;
    localparam [2:0] ST_DOUT  = 3'h5;
    localparam [2:0] ST_SKIP  = 3'h6;

    // ************************************************************
    // Pin sampling and edge finding
    // ************************************************************
    wire [5:0] pins_sync;
    reg        sclk_prev;
    reg        cs_prev;
    wire       cs_n_s  = pins_sync[5];
    wire       sclk_s  = pins_sync[4];
    wire [3:0] io_s    = pins_sync[3:0];
    wire       rise    = sclk_s & ~sclk_prev & ~cs_n_s;
    wire       fall    = ~sclk_s & sclk_prev & ~cs_n_s;
    wire       cs_fall = ~cs_n_s & cs_prev;
    wire       cs_rise = cs_n_s & ~cs_prev;

    // Pins pass together so clock and data stay aligned
    sfcd_pin_sync #(
        .WIDTH (6),
        .INIT  (6'h20)
    ) u_sync (
        .clk   (clk),
        .reset (reset),
        .pin   ({cs_n_pin, sclk_pin, io_in}),
        .level (pins_sync)
    );

    always @(posedge clk) begin
        if (reset) begin
            sclk_prev <= 1'b0;
            cs_prev   <= 1'b1;
        end else begin
            sclk_prev <= sclk_s;
            cs_prev   <= cs_n_s;
        end
    end

    // ************************************************************
    // Command table
    // ************************************************************
    reg  [7:0] opcode;
    wire       t_known;
    wire       t_has_addr;
    wire [2:0] t_addr_lines;
    wire       t_has_dummy;
    wire [2:0] t_dummy_lines;
    wire [1:0] t_dir;
    wire [2:0] t_data_lines;
    wire [3:0] t_gran;
    wire       t_latch;

    sfcd_cmd_table u_table (
        .opcode      (opcode),
        .known       (t_known),
        .has_addr    (t_has_addr),
        .addr_lines  (t_addr_lines),
        .has_dummy   (t_has_dummy),
        .dummy_lines (t_dummy_lines),
        .dir         (t_dir),
        .data_lines  (t_data_lines),
        .gran_mask   (t_gran),
        .needs_latch (t_latch)
    );

    // Opcode shifts in one line before the table sees it
    wire [7:0] opcode_next = {opcode[6:0], io_s[0]};

    // ************************************************************
    // Frame state
    // ************************************************************
    reg [2:0]  state;
    reg [4:0]  bit_cnt;
    reg [23:0] addr;
    reg [7:0]  in_shift;
    reg [7:0]  out_shift;
    reg        out_half;
    reg        frame_ok;
    reg        opc_done;
    reg [2:0]  lines;

    // Bits carried per clock on the active phase width
    always @* begin
        lines = 3'h1;
        case (state)
            ST_ADDR:  lines = t_addr_lines;
            ST_DUMMY: lines = t_dummy_lines;
            ST_DIN:   lines = t_data_lines;
            default:  lines = 3'h1;
        endcase
    end

    wire [4:0] bit_cnt_next = bit_cnt + {2'h0, lines};

    reg [23:0] addr_next;
    reg [7:0]  in_next;
    always @* begin
        addr_next = addr;
        in_next   = in_shift;
        case (lines)
            3'h4: begin
                addr_next = {addr[19:0], io_s};
                in_next   = {in_shift[3:0], io_s};
            end
            3'h2: begin
                addr_next = {addr[21:0], io_s[1:0]};
                in_next   = {in_shift[5:0], io_s[1:0]};
            end
            default: begin
                addr_next = {addr[22:0], io_s[0]};
                in_next   = {in_shift[6:0], io_s[0]};
            end
        endcase
    end

    // Read start address rounded down to the read granule
    wire [23:0] rd_start = {addr_next[23:4], addr_next[3:0] & ~t_gran};

    always @(posedge clk) begin
        if (reset) begin
            state           <= ST_IDLE;
            bit_cnt         <= 5'h00;
            opcode          <= `SFCD_RESET_OPCODE;
            addr            <= `SFCD_RESET_ADDR;
            in_shift        <= 8'h00;
            out_shift       <= 8'h00;
            out_half        <= 1'b0;
            frame_ok        <= 1'b0;
            opc_done        <= 1'b0;
            io_out          <= 4'h0;
            io_oe           <= 4'h0;
            rd_req          <= 1'b0;
            rd_addr         <= `SFCD_RESET_ADDR;
            prog_byte_valid <= 1'b0;
            prog_byte       <= 8'h00;
            prog_addr       <= `SFCD_RESET_ADDR;
        end else begin
            rd_req          <= 1'b0;
            prog_byte_valid <= 1'b0;
            if (cs_n_s) begin
                // Frame ends with chip select high
                state <= ST_IDLE;
                io_oe <= 4'h0;
                if (cs_rise) begin
                    frame_ok <= 1'b0;
                end
            end else if (cs_fall) begin
                state    <= ST_OPC;
                bit_cnt  <= 5'h00;
                addr     <= `SFCD_RESET_ADDR;
                frame_ok <= 1'b0;
                opc_done <= 1'b0;
            end else if (rise) begin
                case (state)
                    ST_OPC: begin
                        opcode  <= opcode_next;
                        bit_cnt <= bit_cnt + 5'h01;
                        if (bit_cnt == {1'b0, `SFCD_OPCODE_BITS} - 5'h01) begin
                            bit_cnt  <= 5'h00;
                            frame_ok <= 1'b1;
                            opc_done <= 1'b1;
                            state    <= ST_SKIP;
                        end
                    end
                    ST_ADDR: begin
                        // Address arrives most significant first
                        addr    <= addr_next;
                        bit_cnt <= bit_cnt_next;
                        if (bit_cnt_next == `SFCD_ADDR_BITS) begin
                            bit_cnt  <= 5'h00;
                            frame_ok <= 1'b1;
                            if (t_has_dummy) begin
                                // Ask for the first byte now; the dummy phase hides the latency
                                state   <= ST_DUMMY;
                                rd_addr <= rd_start;
                                rd_req  <= 1'b1;
                            end else if (t_dir == `SFCD_DIR_IN) begin
                                state     <= ST_DIN;
                                // Steps onto the base address with the first byte
                                prog_addr <= addr_next - 24'h000001;
                            end else begin
                                state <= ST_SKIP;
                            end
                        end else begin
                            frame_ok <= 1'b0;
                        end
                    end
                    ST_DUMMY: begin
                        bit_cnt <= bit_cnt_next;
                        if (bit_cnt_next == {1'b0, `SFCD_DUMMY_BITS}) begin
                            // First byte was asked for at address end
                            state     <= ST_DOUT;
                            out_shift <= rd_byte;
                            out_half  <= 1'b0;
                            rd_addr   <= rd_addr + 24'h000001;
                            rd_req    <= 1'b1;
                        end
                    end
                    ST_DIN: begin
                        in_shift <= in_next;
                        bit_cnt  <= bit_cnt_next;
                        if (bit_cnt_next == {1'b0, `SFCD_BYTE_BITS}) begin
                            bit_cnt <= 5'h00;
                            // Bytes pass only while the latch allows
                            if (write_latch) begin
                                prog_byte_valid <= 1'b1;
                                prog_byte       <= in_next;
                            end
                            prog_addr <= prog_addr + 24'h000001;
                        end
                    end
                    default: begin
                        // Extra clocks after a complete header void it
                        frame_ok <= 1'b0;
                    end
                endcase
            end else if (fall) begin
                if (state == ST_DOUT) begin
                    // Quad output, high nibble first
                    io_oe    <= 4'hf;
                    io_out   <= out_shift[7:4];
                    out_half <= ~out_half;
                    if (out_half) begin
                        out_shift <= rd_byte;
                        rd_addr   <= rd_addr + 24'h000001;
                        rd_req    <= 1'b1;
                    end else begin
                        out_shift <= {out_shift[3:0], 4'h0};
                    end
                end
            end else if (state == ST_SKIP && frame_ok && bit_cnt == 5'h00 && t_known && t_has_addr
                         && opc_done && !sclk_s) begin
                // Opcode just completed: route to address phase
                state    <= ST_ADDR;
                frame_ok <= 1'b0;
                opc_done <= 1'b0;
                bit_cnt  <= 5'h1f;
            end else if (state == ST_ADDR && bit_cnt == 5'h1f) begin
                bit_cnt <= 5'h00;
            end
        end
    end

    // ************************************************************
    // Commands executed at frame end
    // ************************************************************
    wire frame_cmd  = cs_rise & frame_ok & t_known & (t_dir != `SFCD_DIR_OUT) & (state == ST_SKIP || state == ST_DIN);
    wire opc_only   = frame_cmd & ~t_has_addr;
    wire is_suspend = (opcode == `SFCD_OP_SUSPEND_A) | (opcode == `SFCD_OP_SUSPEND_B);
    wire is_resume  = (opcode == `SFCD_OP_RESUME_A) | (opcode == `SFCD_OP_RESUME_B);
    wire is_latch   = opcode == `SFCD_OP_SET_WRITE_LATCH;
    wire go_cmd     = frame_cmd & ~is_suspend & ~is_resume & ~is_latch & (write_latch | ~t_latch);

    always @(posedge clk) begin
        if (reset) begin
            cmd_valid   <= 1'b0;
            cmd_opcode  <= `SFCD_RESET_OPCODE;
            cmd_addr    <= `SFCD_RESET_ADDR;
            suspend_req <= 1'b0;
            resume_req  <= 1'b0;
            write_latch <= 1'b0;
        end else begin
            cmd_valid   <= go_cmd;
            suspend_req <= opc_only & is_suspend;
            resume_req  <= opc_only & is_resume;
            if (go_cmd) begin
                cmd_opcode <= opcode;
                cmd_addr   <= t_has_addr ? addr : `SFCD_RESET_ADDR;
            end
            // Set wins if completion lands on the same cycle
            if (opc_only & is_latch) begin
                write_latch <= 1'b1;
            end else if (op_done) begin
                write_latch <= 1'b0;
            end
        end
    end
endmodule // sfcd_decoder

// >>> tb/sfcd_chk.sv
`timescale 1ns/1ps
// ********
// Port relations of the decoder
// ********
module sfcd_chk (
    input wire        clk,
    input wire        reset,
    input wire        cs_n_pin,
    input wire [3:0]  io_oe,
    input wire        cmd_valid,
    input wire [7:0]  cmd_opcode,
    input wire [23:0] cmd_addr,
    input wire        suspend_req,
    input wire        resume_req,
    input wire        prog_byte_valid,
    input wire        op_done,
    input wire        write_latch
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_oe_idle_cs: assert property (cs_n_pin [*8] |-> io_oe == 4'h0)
        else $error("lines driven while deselected");
    a_oe_quad_only: assert property (io_oe == 4'h0 || io_oe == 4'hf)
        else $error("partial output enable");
    a_cmd_one_pulse: assert property (cmd_valid |=> !cmd_valid)
        else $error("command pulse too long");
    a_cmd_after_cs: assert property (cmd_valid |-> cs_n_pin && $past(cs_n_pin, 2))
        else $error("command inside frame");
    a_cmd_needs_latch: assert property (cmd_valid && cmd_opcode != 8'h36 |-> write_latch)
        else $error("command without latch");
    a_prog_needs_latch: assert property (prog_byte_valid |-> write_latch)
        else $error("program byte without latch");
    a_array_no_addr: assert property (cmd_valid && (cmd_opcode == 8'h60 || cmd_opcode == 8'hc7)
        |-> cmd_addr == 24'h0)
        else $error("array erase with address");
    a_pulse_apart: assert property (suspend_req |-> !resume_req && !cmd_valid)
        else $error("suspend with other pulse");
    a_latch_set_end: assert property ($rose(write_latch) |-> cs_n_pin)
        else $error("latch set inside frame");
    a_done_clears: assert property (op_done && cs_n_pin && $past(cs_n_pin, 8) |=> !write_latch)
        else $error("latch kept after done");
endmodule // sfcd_chk

bind sfcd_decoder sfcd_chk chk_u (.clk, .reset, .cs_n_pin, .io_oe, .cmd_valid, .cmd_opcode, .cmd_addr,
    .suspend_req, .resume_req, .prog_byte_valid, .op_done, .write_latch);

// >>> tb/sfcd_host_model.sv
`timescale 1ns/1ps
// ********
// Serial host: chip select, clock, data lines
// ********
module sfcd_host_model (
    input  wire        clk,
    input  wire  [3:0] io_line,
    output logic       cs_n,
    output logic       sclk,
    output logic [3:0] drv
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        drv = 4'h0;
    end
    // Eight clk a half gives the 64 ns link clock
    task automatic half();
        repeat (8) @(posedge clk);
    endtask
    task automatic start();
        @(posedge clk);
        cs_n <= 1'b0;
        half();
    endtask
    task automatic tick(input logic [3:0] d, output logic [3:0] q);
        drv <= d;
        half();
        sclk <= 1'b1;
        q = io_line;
        half();
        sclk <= 1'b0;
    endtask
    // Msb first; unused lines toggle so nothing stale looks valid
    task automatic shift(input logic [31:0] v, input int n, input int w);
        logic [3:0] q, d;
        for (int i = 0; i < n; i++) begin
            d = ~drv;
            case (w)
                1: d[0] = v[31];
                2: d[1:0] = v[31:30];
                default: d = v[31:28];
            endcase
            v = v << w;
            tick(d, q);
        end
    endtask
    task automatic stop();
        half();
        cs_n <= 1'b1;
        drv <= ~drv;
        repeat (16) @(posedge clk);
        @(negedge clk);
    endtask
endmodule // sfcd_host_model

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    localparam logic [7:0]  ROPS [4] = '{8'h6b, 8'heb, 8'he7, 8'he3};
    localparam logic [23:0] GMSK [4] = '{24'h0, 24'h0, 24'h1, 24'hf};
    localparam logic [7:0]  EOPS [8] = '{8'h81, 8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7, 8'h36, 8'h44};
    localparam logic [7:0]  POPS [4] = '{8'h02, 8'ha2, 8'h32, 8'h42};
    localparam int          PWID [4] = '{1, 2, 4, 1};
    localparam logic [7:0]  SOPS [4] = '{8'h75, 8'hb0, 8'h7a, 8'h30};
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  rd_byte = 8'h00;
    logic        op_done = 1'b0;
    wire  [3:0]  drv, io_in, io_out, io_oe;
    wire         cs_n_pin, sclk_pin, cmd_valid, suspend_req, resume_req, prog_byte_valid, rd_req, write_latch;
    wire  [7:0]  cmd_opcode, prog_byte;
    wire  [23:0] cmd_addr, prog_addr, rd_addr;
    int          err_count = 0;
    int          n_checks = 0;
    int          n_sus = 0;
    int          n_res = 0;
    int          seed = 32'hba8c;
    logic [31:0] cq[$];
    logic [31:0] pq[$];
    always #2 clk = ~clk;
    assign io_in = (io_oe & io_out) | (~io_oe & drv);
    sfcd_decoder dut_u (.clk, .reset, .cs_n_pin, .sclk_pin, .io_in, .io_out, .io_oe, .cmd_valid, .cmd_opcode,
        .cmd_addr, .suspend_req, .resume_req, .prog_byte_valid, .prog_byte, .prog_addr, .rd_req, .rd_addr,
        .rd_byte, .op_done, .write_latch);
    sfcd_host_model host_u (.clk, .io_line(io_in), .cs_n(cs_n_pin), .sclk(sclk_pin), .drv);
    function automatic logic [7:0] arr(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction
    // ********
    // Array stand-in and result capture
    // ********
    always @(posedge clk) begin
        if (rd_req === 1'b1) rd_byte <= arr(rd_addr);
        if (cmd_valid === 1'b1) cq.push_back({cmd_opcode, cmd_addr});
        if (prog_byte_valid === 1'b1) pq.push_back({prog_byte, prog_addr});
        if (suspend_req === 1'b1) n_sus++;
        if (resume_req === 1'b1) n_res++;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic head(input logic [7:0] op, input logic [23:0] a, input int an, input int aw);
        host_u.start();
        host_u.shift({op, 24'h0}, 8, 1);
        if (an > 0) host_u.shift({a, 8'h0}, an, aw);
    endtask
    task automatic latch_on();
        head(8'h06, 24'h0, 0, 1);
        host_u.stop();
        chk(write_latch, 1, "latch set");
    endtask
    task automatic done_pulse();
        @(posedge clk) op_done <= 1'b1;
        @(posedge clk) op_done <= 1'b0;
        @(negedge clk);
        chk(write_latch, 0, "latch clear");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // ********
    // Tests
    // ********
    initial begin
        logic [23:0] a;
        logic [7:0]  d;
        logic [3:0]  hi, lo;
        int          n;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        repeat (10) @(posedge clk);
        foreach (ROPS[i]) begin
            a = 24'($random(seed));
            head(ROPS[i], a, i ? 6 : 24, i ? 4 : 1);
            host_u.shift($random(seed), i ? 2 : 8, i ? 4 : 1);
            a = a & ~GMSK[i];
            for (int k = 0; k < 4; k++) begin
                host_u.tick(~drv, hi);
                host_u.tick(~drv, lo);
                chk({hi, lo}, arr(a + 24'(k)), "read byte");
            end
            host_u.stop();
        end
        $display("test reads done");
        head(8'h20, 24'h012345, 24, 1);
        host_u.stop();
        chk(cq.size(), 0, "erase without latch");
        latch_on();
        head(8'h20, 24'h012345, 16, 1);
        host_u.stop();
        chk(cq.size(), 0, "short header");
        foreach (EOPS[i]) begin
            a = 24'($random(seed));
            n = (EOPS[i] == 8'h60 || EOPS[i] == 8'hc7) ? 0 : 24;
            if (n == 0) a = 24'h0;
            latch_on();
            head(EOPS[i], a, n, 1);
            host_u.stop();
            chk(cq.pop_front(), {EOPS[i], a}, "erase command");
            done_pulse();
        end
        $display("test erases done");
        foreach (POPS[i]) begin
            a = 24'($random(seed));
            latch_on();
            head(POPS[i], a, 24, 1);
            for (int k = 0; k < 3; k++) begin
                d = 8'($random(seed));
                host_u.shift({d, 24'h0}, 8 / PWID[i], PWID[i]);
                chk(pq.pop_front(), {d, a + 24'(k)}, "program byte");
            end
            host_u.stop();
            chk(cq.pop_front(), {POPS[i], a}, "program command");
            done_pulse();
        end
        $display("test programs done");
        foreach (SOPS[i]) begin
            head(SOPS[i], 24'h0, 0, 1);
            host_u.stop();
            chk(n_sus, i < 2 ? i + 1 : 2, "suspends");
            chk(n_res, i < 2 ? 0 : i - 1, "resumes");
        end
        chk(cq.size(), 0, "stray commands");
        $display("test suspend resume done");
        close_out();
    end
    // Run needs about 13k clk; far beyond that means a hang
    initial begin
        #300000;
        err_count++;
        close_out();
    end
endmodule // tb_top
